// [rtl/tcx_pkg.sv]
// tcx_pkg: opcode, field and selector constants for the trap/xor decode slice
// assumes 32-bit instruction words and 64-bit general registers
package tcx_pkg;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 26;
    localparam int RS_MSB = 25;
    localparam int RS_LSB = 21;
    localparam int RT_MSB = 20;
    localparam int RT_LSB = 16;
    localparam int RD_MSB = 15;
    localparam int RD_LSB = 11;
    localparam int SA_MSB = 10;
    localparam int SA_LSB = 6;
    localparam int FN_MSB = 5;
    localparam int FN_LSB = 0;
    localparam int IMM_MSB = 15;
    localparam int COPROC_OP_BIT = 25;
    localparam int XLEN = 64;
    localparam int IMMW = 16;
    // ----------------------------------------------------------------
    // major opcodes
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_REG_IMM = 6'h01;
    localparam logic [5:0] OP_SYS_COP = 6'h10;
    localparam logic [5:0] OP_XOR_IMM = 6'h0e;
    // ----------------------------------------------------------------
    // special function codes
    // ----------------------------------------------------------------
    localparam logic [5:0] FN_TRAP_SLT = 6'h32;
    localparam logic [5:0] FN_TRAP_ULT = 6'h33;
    localparam logic [5:0] FN_TRAP_NE = 6'h36;
    localparam logic [5:0] FN_XOR = 6'h26;
    // ----------------------------------------------------------------
    // register-immediate selectors and coprocessor functions
    // ----------------------------------------------------------------
    localparam logic [4:0] SEL_TRAP_SLT = 5'h0a;
    localparam logic [4:0] SEL_TRAP_ULT = 5'h0b;
    localparam logic [4:0] SEL_TRAP_NE = 5'h0e;
    localparam logic [5:0] FN_WAIT = 6'h20;
    localparam logic [5:0] FN_TW_INDEXED = 6'h02;
    localparam logic [5:0] FN_TW_RANDOM = 6'h06;
    localparam logic [4:0] SHAMT_ZERO = 5'h00;
endpackage : tcx_pkg

// [rtl/tcx_decode.sv]
// tcx_decode: decodes and executes trap, exclusive-or and wait instructions
// assumes operands are read by the pipeline and presented with the word;
// one instruction per valid cycle, in program order
module tcx_decode
    import tcx_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] rs_value,
    input wire logic [63:0] rt_value,
    input wire logic sys_cop_usable,
    input wire logic wake,
    output logic wb_valid,
    output logic [4:0] wb_addr,
    output logic [63:0] wb_data,
    output logic trap_exc,
    output logic cop_unusable_exc,
    output logic pipe_halted
);
    // ----------------------------------------------------------------
    // field extraction
    // ----------------------------------------------------------------
    logic [5:0] op;
    logic [5:0] fn;
    logic [4:0] rt_f;
    logic [4:0] rd_f;
    logic [4:0] sa_f;
    logic [63:0] imm_sext;
    logic [63:0] imm_zext;
    assign op = instr_word[OP_MSB:OP_LSB];
    assign fn = instr_word[FN_MSB:FN_LSB];
    assign rt_f = instr_word[RT_MSB:RT_LSB];
    assign rd_f = instr_word[RD_MSB:RD_LSB];
    // the shift field only matters to the register xor, which wants it zero
    assign sa_f = instr_word[SA_MSB:SA_LSB];
    assign imm_sext = {{(XLEN-IMMW){instr_word[IMM_MSB]}}, instr_word[IMM_MSB:0]};
    assign imm_zext = {{(XLEN-IMMW){1'b0}}, instr_word[IMM_MSB:0]};

    // ----------------------------------------------------------------
    // run/halt state
    // ----------------------------------------------------------------
    typedef enum logic {
        ST_RUN = 1'b0,
        ST_HALTED = 1'b1
    } tcx_run_state_t;

    tcx_run_state_t state_reg;
    tcx_run_state_t state_next;

    // ----------------------------------------------------------------
    // instruction class decode
    // ----------------------------------------------------------------
    // a word is taken only while running; a halted pipeline drops it
    logic take;
    logic is_special_op;
    logic is_register_immediate_major_op;
    logic is_system_coprocessor_op;
    logic coprocessor_operation_bit;
    logic dec_trap_signed_lt_reg;
    logic dec_trap_unsigned_lt_reg;
    logic dec_trap_not_equal_reg;
    logic dec_exclusive_or_reg;
    logic dec_trap_signed_lt_imm;
    logic dec_trap_unsigned_lt_imm;
    logic dec_trap_not_equal_imm;
    logic dec_exclusive_or_imm;
    logic dec_wait;
    logic dec_translation_write_indexed;
    logic dec_translation_write_random;

    assign take = instr_valid && (state_reg == ST_RUN);
    assign is_special_op = take && (op == OP_SPECIAL);
    assign is_register_immediate_major_op = take && (op == OP_REG_IMM);
    assign is_system_coprocessor_op = take && (op == OP_SYS_COP);
    assign coprocessor_operation_bit = instr_word[COPROC_OP_BIT];

    // register traps match on the function code only: the ten-bit code
    // field in bits 15..6 is left to the handler, which rereads the word
    assign dec_trap_signed_lt_reg = is_special_op && (fn == FN_TRAP_SLT);
    assign dec_trap_unsigned_lt_reg = is_special_op && (fn == FN_TRAP_ULT);
    assign dec_trap_not_equal_reg = is_special_op && (fn == FN_TRAP_NE);
    // a nonzero shift field makes the register xor a silent no-op
    assign dec_exclusive_or_reg = is_special_op && (fn == FN_XOR)
        && (sa_f == SHAMT_ZERO);
    assign dec_trap_signed_lt_imm = is_register_immediate_major_op
        && (rt_f == SEL_TRAP_SLT);
    assign dec_trap_unsigned_lt_imm = is_register_immediate_major_op
        && (rt_f == SEL_TRAP_ULT);
    assign dec_trap_not_equal_imm = is_register_immediate_major_op
        && (rt_f == SEL_TRAP_NE);
    assign dec_exclusive_or_imm = take && (op == OP_XOR_IMM);
    assign dec_wait = is_system_coprocessor_op && coprocessor_operation_bit
        && (fn == FN_WAIT);
    assign dec_translation_write_indexed = is_system_coprocessor_op
        && coprocessor_operation_bit && (fn == FN_TW_INDEXED);
    assign dec_translation_write_random = is_system_coprocessor_op
        && coprocessor_operation_bit && (fn == FN_TW_RANDOM);

    // ----------------------------------------------------------------
    // operand comparisons
    // ----------------------------------------------------------------
    // all six compares run every cycle; the decode picks the one that counts
    logic lt_signed_reg;
    logic lt_unsigned_reg;
    logic ne_reg;
    logic lt_signed_imm;
    logic lt_unsigned_imm;
    logic ne_imm;

    assign lt_signed_reg = $signed(rs_value) < $signed(rt_value);
    assign lt_unsigned_reg = rs_value < rt_value;
    assign ne_reg = rs_value != rt_value;
    assign lt_signed_imm = $signed(rs_value) < $signed(imm_sext);
    // the immediate is sign-extended first, then both sides are read unsigned
    assign lt_unsigned_imm = rs_value < imm_sext;
    assign ne_imm = rs_value != imm_sext;

    // ----------------------------------------------------------------
    // exception reporting
    // ----------------------------------------------------------------
    logic trap_reg;
    logic trap_next;
    logic cpu_reg;
    logic cpu_next;

    always_comb begin
        trap_next = 1'b0;
        cpu_next = 1'b0;
        if (dec_trap_signed_lt_reg) begin
            trap_next = lt_signed_reg;
        end else if (dec_trap_unsigned_lt_reg) begin
            trap_next = lt_unsigned_reg;
        end else if (dec_trap_not_equal_reg) begin
            trap_next = ne_reg;
        end else if (dec_trap_signed_lt_imm) begin
            trap_next = lt_signed_imm;
        end else if (dec_trap_unsigned_lt_imm) begin
            trap_next = lt_unsigned_imm;
        end else if (dec_trap_not_equal_imm) begin
            trap_next = ne_imm;
        end else if (dec_translation_write_indexed || dec_translation_write_random) begin
            // left unimplemented: no trap is promised, so none is raised
            trap_next = 1'b0;
        end
        // without the system coprocessor a wait reports instead of halting
        if (dec_wait) begin
            cpu_next = ~sys_cop_usable;
        end
    end

    // one pulse per taken word, so the exception unit sees them in order
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trap_reg <= 1'b0;
            cpu_reg <= 1'b0;
        end else begin
            trap_reg <= trap_next;
            cpu_reg <= cpu_next;
        end
    end

    // ----------------------------------------------------------------
    // result writeback
    // ----------------------------------------------------------------
    logic wb_valid_reg;
    logic wb_valid_next;
    logic [4:0] wb_addr_reg;
    logic [4:0] wb_addr_next;
    logic [63:0] wb_data_reg;
    logic [63:0] wb_data_next;

    always_comb begin
        wb_valid_next = 1'b0;
        wb_addr_next = wb_addr_reg;
        wb_data_next = wb_data_reg;
        if (dec_exclusive_or_reg) begin
            wb_valid_next = 1'b1;
            wb_addr_next = rd_f;
            wb_data_next = rs_value ^ rt_value;
        end else if (dec_exclusive_or_imm) begin
            wb_valid_next = 1'b1;
            wb_addr_next = rt_f;
            wb_data_next = rs_value ^ imm_zext;
        end
        // a trapping word never leaves a result behind
        if (trap_next) begin
            wb_valid_next = 1'b0;
        end
    end

    // address and data hold between writes to save toggling on the wide bus
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_valid_reg <= 1'b0;
            wb_addr_reg <= 5'h00;
            wb_data_reg <= 64'h0000_0000_0000_0000;
        end else begin
            wb_valid_reg <= wb_valid_next;
            wb_addr_reg <= wb_addr_next;
            wb_data_reg <= wb_data_next;
        end
    end

    // ----------------------------------------------------------------
    // wait halt
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                // a wake in the same cycle as the wait cancels the halt
                if (dec_wait && sys_cop_usable && !wake) begin
                    state_next = ST_HALTED;
                end
            end
            ST_HALTED: begin
                // limitation: nothing but the wake input or a reset ends a halt
                if (wake) begin
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign wb_valid = wb_valid_reg;
    assign wb_addr = wb_addr_reg;
    assign wb_data = wb_data_reg;
    assign trap_exc = trap_reg;
    assign cop_unusable_exc = cpu_reg;
    assign pipe_halted = (state_reg == ST_HALTED);
endmodule : tcx_decode

// [tb/tcx_decode_monitor.sv]
// checker: result and exception timing of the trap, xor and wait decode
// sees only the decoder's ports, one clock domain
module tcx_decode_monitor
    import tcx_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [63:0] rs_value,
    input wire logic [63:0] rt_value,
    input wire logic sys_cop_usable,
    input wire logic wake,
    input wire logic wb_valid,
    input wire logic [4:0] wb_addr,
    input wire logic [63:0] wb_data,
    input wire logic trap_exc,
    input wire logic cop_unusable_exc,
    input wire logic pipe_halted
);
    wire [5:0] op = instr_word[31:26];
    wire [5:0] fn = instr_word[5:0];
    wire [4:0] rd = instr_word[15:11];
    wire sp = op == OP_SPECIAL;
    wire wt = op == OP_SYS_COP && instr_word[COPROC_OP_BIT] && fn == FN_WAIT;
    wire [63:0] xr = rs_value ^ rt_value;
    wire [63:0] xi = rs_value ^ {48'h0, instr_word[15:0]};
    wire [63:0] sx = {{48{instr_word[15]}}, instr_word[15:0]};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        instr_valid && !pipe_halted;
    endsequence
    sequence s_halted;
        pipe_halted && !wake;
    endsequence
    a_xor_reg_write: assert property (s_take ##0 (sp && fn == FN_XOR && rd != 0 &&
        instr_word[10:6] == SHAMT_ZERO) |=> wb_valid && wb_addr == $past(rd) && wb_data == $past(xr))
        else $error("xor result wrong");
    a_xor_imm_write: assert property (s_take ##0 (op == OP_XOR_IMM)
        |=> wb_valid && !trap_exc && wb_data == $past(xi)) else $error("xor imm result wrong");
    a_slt_reg_trap: assert property (s_take ##0 (sp && fn == FN_TRAP_SLT &&
        $signed(rs_value) < $signed(rt_value)) |=> trap_exc) else $error("signed trap missed");
    a_ult_imm_trap: assert property (s_take ##0 (op == OP_REG_IMM &&
        instr_word[20:16] == SEL_TRAP_ULT && rs_value < sx) |=> trap_exc) else $error("ult trap missed");
    a_trap_no_write: assert property (trap_exc |-> !wb_valid) else $error("trap wrote back");
    a_wait_halt: assert property (s_take ##0 (wt && sys_cop_usable && !wake)
        |=> pipe_halted && !cop_unusable_exc) else $error("wait did not halt");
    a_wait_unusable: assert property (s_take ##0 (wt && !sys_cop_usable)
        |=> cop_unusable_exc && !pipe_halted) else $error("wait unusable missed");
    a_twrite_silent: assert property (s_take ##0 (op == OP_SYS_COP &&
        (fn == FN_TW_INDEXED || fn == FN_TW_RANDOM)) |=> !wb_valid) else $error("twrite wrote");
    a_halt_hold: assert property (s_halted |=> pipe_halted && !wb_valid && !trap_exc)
        else $error("halt left early");
    a_wake_release: assert property (pipe_halted && wake |=> !pipe_halted)
        else $error("wake ignored");
    a_ne_reg_trap: assert property (s_take ##0 (sp && fn == FN_TRAP_NE &&
        rs_value != rt_value) |=> trap_exc) else $error("not-equal trap missed");
endmodule : tcx_decode_monitor
bind tcx_decode tcx_decode_monitor i_mon (.core_clk, .rst_n, .instr_valid, .instr_word,
    .rs_value, .rt_value, .sys_cop_usable, .wake, .wb_valid, .wb_addr, .wb_data, .trap_exc,
    .cop_unusable_exc, .pipe_halted);

// [tb/trap_compare_xor_decode_bench.sv]
// bench: directed trap, xor, wait and translation-write cases
// drives the decoder ports 2 ns after each rising edge
module trap_compare_xor_decode_bench
    import tcx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] M1 = 64'hffff_ffff_ffff_ffff;
    localparam logic [31:0] WT = {OP_SYS_COP, 20'h8_0000, FN_WAIT};
    logic core_clk = 0, rst_n = 0, instr_valid = 0, sys_cop_usable = 1, wake = 0;
    logic [31:0] instr_word = 32'h0000_0000;
    logic [63:0] rs_value = M1, rt_value = M1, wb_data;
    logic wb_valid, trap_exc, cop_unusable_exc, pipe_halted;
    logic [4:0] wb_addr;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    always #12.5 core_clk = ~core_clk;
    tcx_decode i_dut (.core_clk, .rst_n, .instr_valid, .instr_word, .rs_value, .rt_value,
        .sys_cop_usable, .wake, .wb_valid, .wb_addr, .wb_data, .trap_exc, .cop_unusable_exc,
        .pipe_halted);
    task give_verdict;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    // wb_valid and the exception pulses stand one cycle, so outputs are read 2 ns after the answering edge
    task run(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
        @(posedge core_clk) #2 {instr_valid, instr_word, rs_value, rt_value} = {1'b1, w, a, b};
        @(posedge core_clk) #2 instr_valid = 0;
    endtask : run
    // all-ones code field: it must not change the outcome
    function automatic logic [31:0] rw(input logic [5:0] f);
        return {OP_SPECIAL, 20'hf_ffff, f};
    endfunction : rw
    task tr(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b, input logic e);
        run(w, a, b);
        check(trap_exc, e);
        check(wb_valid, 1'b0);
    endtask : tr
    task t_traps;
        tr(rw(FN_TRAP_SLT), M1, 64'h1, 1'b1);
        tr(rw(FN_TRAP_SLT), 64'h1, M1, 1'b0);
        tr(rw(FN_TRAP_ULT), M1, 64'h1, 1'b0);
        tr(rw(FN_TRAP_ULT), 64'h1, M1, 1'b1);
        tr(rw(FN_TRAP_NE), M1, M1, 1'b0);
        tr(rw(FN_TRAP_NE), M1, 64'h0, 1'b1);
        tr({OP_REG_IMM, 5'h1f, SEL_TRAP_SLT, 16'hffff}, M1 << 1, M1, 1'b1);
        tr({OP_REG_IMM, 5'h1f, SEL_TRAP_SLT, 16'hffff}, 64'h0, M1, 1'b0);
        tr({OP_REG_IMM, 5'h1f, SEL_TRAP_ULT, 16'hffff}, 64'h1_0000, M1, 1'b1);
        tr({OP_REG_IMM, 5'h1f, SEL_TRAP_NE, 16'h8000}, M1 << 15, M1, 1'b0);
        tr({OP_REG_IMM, 5'h1f, SEL_TRAP_NE, 16'h8000}, 64'h8000, M1, 1'b1);
    endtask : t_traps
    task t_xor;
        run({OP_SPECIAL, 15'h0447, SHAMT_ZERO, FN_XOR}, 64'h1234_5678_9abc_def0, M1);
        check({wb_valid, wb_addr}, 6'h27);
        check(wb_data, 64'hedcb_a987_6543_210f);
        run({OP_XOR_IMM, 10'h029, 16'h8001}, M1, M1);
        check({wb_valid, trap_exc, wb_addr}, 7'h49);
        check(wb_data, 64'hffff_ffff_ffff_7ffe);
        run({OP_SPECIAL, 15'h0447, 5'h01, FN_XOR}, M1, M1);
        check(wb_valid, 1'b0);
    endtask : t_xor
    task t_wait;
        run(WT, M1, M1);
        check(pipe_halted, 1'b1);
        run({OP_XOR_IMM, 10'h029, 16'h8001}, M1, M1);
        check(wb_valid, 1'b0);
        @(posedge core_clk) #2 wake = 1;
        @(posedge core_clk) #2 wake = 0;
        check(pipe_halted, 1'b0);
        sys_cop_usable = 0;
        run(WT, M1, M1);
        check({cop_unusable_exc, pipe_halted}, 2'h2);
        sys_cop_usable = 1;
    endtask : t_wait
    task t_twrite;
        run({OP_SYS_COP, 20'h8_0000, FN_TW_INDEXED}, M1, M1);
        check({wb_valid, cop_unusable_exc, trap_exc}, 3'h0);
        run({OP_SYS_COP, 20'h8_0000, FN_TW_RANDOM}, M1, M1);
        check({wb_valid, cop_unusable_exc, trap_exc}, 3'h0);
    endtask : t_twrite
    initial begin
        repeat (16) @(posedge core_clk);
        #2 rst_n = 1;
        t_traps;
        t_xor;
        t_wait;
        t_twrite;
        give_verdict;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            give_verdict;
        end
    end
endmodule : trap_compare_xor_decode_bench
